// File: src/tapc_consts.svh
`ifndef TAPC_CONSTS_SVH
`define TAPC_CONSTS_SVH
`define TAPC_IR_WIDTH 4
`define TAPC_IR_RESET 4'h1
`define TAPC_IR_BYPASS 4'hF
`define TAPC_IR_IDCODE 4'h1
`define TAPC_IR_SCAN 4'h2
`define TAPC_ID_WIDTH 32
`define TAPC_ID_VALUE 32'h1234_5001
`define TAPC_SCAN_WIDTH 8
`define TAPC_STRAP_WAIT 2'h3
`endif

// File: src/tapc_pkg.sv
package tapc_pkg;
   typedef enum logic [15:0] {
      TAPC_RESET = 16'h0001,
      TAPC_IDLE = 16'h0002,
      TAPC_SEL_DR = 16'h0004,
      TAPC_CAP_DR = 16'h0008,
      TAPC_SH_DR = 16'h0010,
      TAPC_EX1_DR = 16'h0020,
      TAPC_PA_DR = 16'h0040,
      TAPC_EX2_DR = 16'h0080,
      TAPC_UPD_DR = 16'h0100,
      TAPC_SEL_IR = 16'h0200,
      TAPC_CAP_IR = 16'h0400,
      TAPC_SH_IR = 16'h0800,
      TAPC_EX1_IR = 16'h1000,
      TAPC_PA_IR = 16'h2000,
      TAPC_EX2_IR = 16'h4000,
      TAPC_UPD_IR = 16'h8000
   } tapc_state_t;
endpackage

// File: src/tapc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tapc_consts.svh"
module tapc_top
   import tapc_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Test pins
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic second_test_mode_select_in,
   input wire logic trst_in,
   input wire logic tdi_in,
   input wire logic emulation_line_zero_in,
   input wire logic output_disable_line_in,
   output logic tdo_out,
   output logic tdo_oe_out,
   // Mode outputs
   output logic scan_control_out,
   output logic pll_bypass_out,
   output tapc_pkg::tapc_state_t tap_state_out,
   // Strobes from the memory interface and their shared enable
   input wire logic data_space_strobe_n_in,
   input wire logic io_space_strobe_n_in,
   input wire logic program_space_strobe_n_in,
   output logic data_space_strobe_n_out,
   output logic io_space_strobe_n_out,
   output logic program_space_strobe_n_out,
   output logic strobe_oe_out
);
   import tapc_pkg::*;

   logic [1:0] rst_sync_q;
   logic rst_n;
   // Pin synchronisers: first stage read only by second
   logic [6:0] s1_q, s2_q, s2_d;
   logic tck_prev_q, tck_prev_d;
   logic tck, tms, second_test_mode_select, trst, tdi, emulation_line_zero, offn;
   logic rise, fall;
   tapc_state_t st_q, st_d;
   logic [`TAPC_IR_WIDTH-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
   logic [`TAPC_ID_WIDTH-1:0] dr_q, dr_d;
   logic [`TAPC_SCAN_WIDTH-1:0] scan_q, scan_d;
   logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
   logic strap_done_q, strap_done_d, byp_q, byp_d, strap_ok_q, strap_ok_d;
   // Counts the cycles until the synchronised pins hold real levels
   logic [1:0] strap_cnt_q, strap_cnt_d;
   logic scan_q_o, scan_d_o, oe_q, oe_d;
   logic [2:0] strb_q, strb_d;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign {tck, tms, second_test_mode_select, trst, tdi, emulation_line_zero, offn} = s2_q;
   assign rise = tck && !tck_prev_q;
   assign fall = !tck && tck_prev_q;

   function automatic tapc_state_t next_state(input tapc_state_t s, input logic m);
      unique case (s)
         TAPC_RESET: next_state = m ? TAPC_RESET : TAPC_IDLE;
         TAPC_IDLE: next_state = m ? TAPC_SEL_DR : TAPC_IDLE;
         TAPC_SEL_DR: next_state = m ? TAPC_SEL_IR : TAPC_CAP_DR;
         TAPC_CAP_DR: next_state = m ? TAPC_EX1_DR : TAPC_SH_DR;
         TAPC_SH_DR: next_state = m ? TAPC_EX1_DR : TAPC_SH_DR;
         TAPC_EX1_DR: next_state = m ? TAPC_UPD_DR : TAPC_PA_DR;
         TAPC_PA_DR: next_state = m ? TAPC_EX2_DR : TAPC_PA_DR;
         TAPC_EX2_DR: next_state = m ? TAPC_UPD_DR : TAPC_SH_DR;
         TAPC_UPD_DR: next_state = m ? TAPC_SEL_DR : TAPC_IDLE;
         TAPC_SEL_IR: next_state = m ? TAPC_RESET : TAPC_CAP_IR;
         TAPC_CAP_IR: next_state = m ? TAPC_EX1_IR : TAPC_SH_IR;
         TAPC_SH_IR: next_state = m ? TAPC_EX1_IR : TAPC_SH_IR;
         TAPC_EX1_IR: next_state = m ? TAPC_UPD_IR : TAPC_PA_IR;
         TAPC_PA_IR: next_state = m ? TAPC_EX2_IR : TAPC_PA_IR;
         TAPC_EX2_IR: next_state = m ? TAPC_UPD_IR : TAPC_SH_IR;
         TAPC_UPD_IR: next_state = m ? TAPC_SEL_DR : TAPC_IDLE;
         default: next_state = TAPC_RESET;
      endcase
   endfunction

   // Selected data register length depends on instruction
   function automatic int unsigned dr_len(input logic [`TAPC_IR_WIDTH-1:0] ir);
      if (ir == `TAPC_IR_IDCODE) begin
         dr_len = `TAPC_ID_WIDTH;
      end else if (ir == `TAPC_IR_SCAN) begin
         dr_len = `TAPC_SCAN_WIDTH;
      end else begin
         dr_len = 1;
      end
   endfunction

   always_comb begin
      s2_d = s1_q;
      tck_prev_d = tck;
      st_d = st_q;
      ir_sh_d = ir_sh_q;
      ir_d = ir_q;
      dr_d = dr_q;
      scan_d = scan_q;
      tdo_d = tdo_q;
      tdo_oe_d = tdo_oe_q;
      // Low test reset holds the controller in reset: scan resets have no effect
      if (!trst) begin
         st_d = TAPC_RESET;
         ir_d = `TAPC_IR_RESET;
         tdo_oe_d = 1'b0;
      end else if (rise) begin
         // Both selects must be high to steer with a one; the second floats high when open
         st_d = next_state(st_q, tms && second_test_mode_select);
         unique case (st_q)
            TAPC_CAP_IR: ir_sh_d = `TAPC_IR_WIDTH'(1);
            TAPC_SH_IR: ir_sh_d = {tdi, ir_sh_q[`TAPC_IR_WIDTH-1:1]};
            TAPC_UPD_IR: ir_d = ir_sh_q;
            TAPC_CAP_DR: begin
               dr_d = (ir_q == `TAPC_IR_IDCODE) ? `TAPC_ID_VALUE : '0;
               if (ir_q == `TAPC_IR_SCAN) begin
                  dr_d[`TAPC_SCAN_WIDTH-1:0] = scan_q;
               end
            end
            TAPC_SH_DR: begin
               dr_d = dr_q >> 1;
               dr_d[dr_len(ir_q)-1] = tdi;
            end
            TAPC_UPD_DR: begin
               if (ir_q == `TAPC_IR_SCAN) begin
                  scan_d = dr_q[`TAPC_SCAN_WIDTH-1:0];
               end
            end
            TAPC_RESET: ir_d = `TAPC_IR_RESET;
            default: ;
         endcase
      end else if (fall) begin
         // Output changes on the falling edge so the pod samples it stable on the rise
         tdo_oe_d = (st_q == TAPC_SH_DR) || (st_q == TAPC_SH_IR);
         tdo_d = (st_q == TAPC_SH_IR) ? ir_sh_q[0] : dr_q[0];
      end
   end

   // Strap: PLL bypass latched once, from the pin levels held over reset
   // The synchronisers reset to zero, so their first outputs would fake a strap;
   // the latch waits until the pins have reached the registered condition
   always_comb begin
      strap_ok_d = !tms && !second_test_mode_select && !trst;
      strap_cnt_d = strap_done_q ? strap_cnt_q : strap_cnt_q + 2'h1;
      strap_done_d = strap_done_q || (strap_cnt_q == `TAPC_STRAP_WAIT);
      if (!strap_done_q && (strap_cnt_q == `TAPC_STRAP_WAIT)) begin
         byp_d = strap_ok_q;
      end else begin
         byp_d = byp_q;
      end
      scan_d_o = trst;
      oe_d = !(!offn && !trst && emulation_line_zero);
      strb_d = {data_space_strobe_n_in, io_space_strobe_n_in, program_space_strobe_n_in};
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 7'h00;
         s2_q <= 7'h00;
         tck_prev_q <= 1'b0;
         st_q <= TAPC_RESET;
         ir_sh_q <= 4'h0;
         ir_q <= `TAPC_IR_RESET;
         dr_q <= 32'h0000_0000;
         scan_q <= 8'h00;
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
         strap_ok_q <= 1'b1;
         strap_done_q <= 1'b0;
         strap_cnt_q <= 2'h0;
         byp_q <= 1'b0;
         scan_q_o <= 1'b0;
         oe_q <= 1'b1;
         strb_q <= 3'h7;
      end else begin
         s1_q <= {tck_in, tms_in, second_test_mode_select_in, trst_in, tdi_in,
                  emulation_line_zero_in, output_disable_line_in};
         s2_q <= s2_d;
         tck_prev_q <= tck_prev_d;
         st_q <= st_d;
         ir_sh_q <= ir_sh_d;
         ir_q <= ir_d;
         dr_q <= dr_d;
         scan_q <= scan_d;
         tdo_q <= tdo_d;
         tdo_oe_q <= tdo_oe_d;
         strap_ok_q <= strap_ok_d;
         strap_done_q <= strap_done_d;
         strap_cnt_q <= strap_cnt_d;
         byp_q <= byp_d;
         scan_q_o <= scan_d_o;
         oe_q <= oe_d;
         strb_q <= strb_d;
      end
   end

   // Every output is a register copy; pins reach them three clocks late at most, pll_bypass_out four
   assign tdo_out = tdo_q;
   assign tdo_oe_out = tdo_oe_q;
   assign scan_control_out = scan_q_o;
   assign pll_bypass_out = byp_q;
   assign tap_state_out = st_q;
   assign {data_space_strobe_n_out, io_space_strobe_n_out, program_space_strobe_n_out} = strb_q;
   assign strobe_oe_out = oe_q;
endmodule
`default_nettype wire

// File: verif/tapc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tapc_assertions
   import tapc_pkg::*;
(
   // Watched ports
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic second_test_mode_select_in,
   input wire logic trst_in,
   input wire logic emulation_line_zero_in,
   input wire logic output_disable_line_in,
   input wire logic tdo_out,
   input wire logic tdo_oe_out,
   input wire logic scan_control_out,
   input wire tapc_pkg::tapc_state_t tap_state_out,
   input wire logic strobe_oe_out
);
   logic off_c;
   assign off_c = !output_disable_line_in && !trst_in && emulation_line_zero_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   state_still_a: assert property (
      (scan_control_out && !tck_in)[*3] |-> $stable(tap_state_out)) else $error("state moved");
   both_sel_a: assert property (
      scan_control_out && $past(tap_state_out) == TAPC_IDLE && tap_state_out == TAPC_SEL_DR
      |-> $past(tms_in, 4) && $past(second_test_mode_select_in, 4)) else $error("select");
   scan_ctl_a: assert property (trst_in[*5] |-> scan_control_out)
      else $error("no scan control");
   func_mode_a: assert property ((!trst_in)[*5] |->
      !scan_control_out && !tdo_oe_out && tap_state_out == TAPC_RESET) else $error("not functional");
   float_on_a: assert property (off_c[*5] |-> !strobe_oe_out) else $error("no float");
   float_only_a: assert property (!strobe_oe_out |->
      $past(off_c, 2) || $past(off_c, 3) || $past(off_c, 4)) else $error("bad float");
   tdo_fall_a: assert property (
      scan_control_out && $changed(tdo_out) |-> !$past(tck_in, 2)) else $error("tdo edge");
   reset_exit_a: assert property (
      scan_control_out && $past(tap_state_out) == TAPC_RESET && tap_state_out != TAPC_RESET
      |-> tap_state_out == TAPC_IDLE) else $error("reset exit");
   cover property (tap_state_out == TAPC_SH_DR);
   cover property (!strobe_oe_out);
   cover property ($rose(scan_control_out));
endmodule
bind tapc_top tapc_assertions u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .tck_in(tck_in),
   .tms_in(tms_in), .second_test_mode_select_in(second_test_mode_select_in),
   .trst_in(trst_in), .emulation_line_zero_in(emulation_line_zero_in),
   .output_disable_line_in(output_disable_line_in), .tdo_out(tdo_out),
   .tdo_oe_out(tdo_oe_out), .scan_control_out(scan_control_out),
   .tap_state_out(tap_state_out), .strobe_oe_out(strobe_oe_out));
`default_nettype wire

// File: verif/tapc_pod.sv
`timescale 1ns/1ps
`default_nettype none
module tapc_pod (
   // Test pins
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   output logic trst_out,
   input wire logic tdo_in
);
   // All low through device reset
   initial {tck_out, tms_out, tdi_out, trst_out} = 4'h0;
   task automatic set_trst(input logic v);
      trst_out <= v;
   endtask
   // Edges sit off the clock grid; tdo read just after the rise
   task automatic step(input logic m, input logic d, output logic q);
      #5 tms_out = m;
      tdi_out = d;
      #92 tck_out = 1'h1;
      #2 q = tdo_in;
      #98 tck_out = 1'h0;
      #3;
   endtask
   // Idle, select, capture, shift, exit, update, idle
   task automatic scan(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'h1, 1'h1, q);
      if (ir) step(1'h1, 1'h1, q);
      step(1'h0, 1'h1, q);
      step(1'h0, 1'h1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'h1, 1'h1, q);
      step(1'h0, 1'h1, q);
   endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tapc_consts.svh"
module tb;
   import tapc_pkg::*;
   logic clk_in = 1'h0, rst_n_in = 1'h0, sel2 = 1'h0, emulation_line_zero = 1'h1, off = 1'h1;
   logic tck, tms, tdi, trst, tdo, tdo_oe, scan_ctl, bypass, strobe_oe, q;
   logic [2:0] s_in = 3'h5, s_out;
   logic [31:0] rd;
   tapc_state_t st;
   int mismatches = 0, total_checks = 0;
   always #12.5 clk_in = ~clk_in;
   tapc_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms),
      .second_test_mode_select_in(sel2), .trst_in(trst), .tdi_in(tdi),
      .emulation_line_zero_in(emulation_line_zero), .output_disable_line_in(off), .tdo_out(tdo),
      .tdo_oe_out(tdo_oe), .scan_control_out(scan_ctl), .pll_bypass_out(bypass),
      .tap_state_out(st), .data_space_strobe_n_in(s_in[2]), .io_space_strobe_n_in(s_in[1]),
      .program_space_strobe_n_in(s_in[0]), .data_space_strobe_n_out(s_out[2]),
      .io_space_strobe_n_out(s_out[1]), .program_space_strobe_n_out(s_out[0]),
      .strobe_oe_out(strobe_oe));
   tapc_pod u_pod (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_out(trst), .tdo_in(tdo));
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic complete_run();
      if (mismatches == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic t_scan();
      check(bypass, 1'h1, "strap");
      sel2 <= 1'h1;
      u_pod.set_trst(1'h1);
      repeat (8) @(posedge clk_in);
      check(scan_ctl, 1'h1, "scan control");
      u_pod.step(1'h0, 1'h1, q);
      check(st, TAPC_IDLE, "idle");
      u_pod.scan(1'h0, 32, 32'h0, rd);
      check(rd, `TAPC_ID_VALUE, "id");
      u_pod.scan(1'h1, 4, 32'hF, rd);
      check(rd, 32'h1, "ir capture");
      u_pod.scan(1'h0, 2, 32'h1, rd);
      check(rd, 32'h2, "bypass");
   endtask
   task automatic t_second();
      @(posedge clk_in) sel2 <= 1'h0;
      u_pod.step(1'h1, 1'h1, q);
      check(st, TAPC_IDLE, "sel2 low");
      @(posedge clk_in) sel2 <= 1'h1;
      u_pod.step(1'h1, 1'h1, q);
      check(st, TAPC_SEL_DR, "sel dr");
      u_pod.step(1'h1, 1'h1, q);
      u_pod.step(1'h1, 1'h1, q);
      check(st, TAPC_RESET, "to reset");
   endtask
   task automatic t_off();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_in) off <= i[0];
         s_in <= i[2:0];
         emulation_line_zero <= i[1];
         u_pod.set_trst(i[2]);
         repeat (8) @(posedge clk_in);
         check(strobe_oe, i != 2, "float");
         check(s_out, s_in, "strobes");
      end
      u_pod.set_trst(1'h0);
      u_pod.step(1'h0, 1'h1, q);
      check({scan_ctl, tdo_oe, st}, {2'h0, TAPC_RESET}, "functional");
   endtask
   task automatic t_reset();
      @(posedge clk_in) rst_n_in <= 1'h0;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'h1;
      repeat (8) @(posedge clk_in);
      check(bypass, 1'h0, "no strap");
      check(st, TAPC_RESET, "state after reset");
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'h1;
      repeat (8) @(posedge clk_in);
      t_scan();
      t_second();
      t_off();
      t_reset();
      complete_run();
   end
   initial begin
      #2_000_000;
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire
